// ### src/pcr_pkg.sv
package pcr_pkg;
  // Register offsets (7-bit serial address space)
  localparam logic [6:0] PCR_ADDR_Z_TRIM    = 7'h73;
  localparam logic [6:0] PCR_ADDR_POWER_SAVING_CONFIG  = 7'h7C;
  localparam logic [6:0] PCR_ADDR_SENS_EN   = 7'h7D;
  localparam logic [6:0] PCR_ADDR_CMD_ENTRY = 7'h7E;

  // Reset values
  localparam logic [7:0] PCR_RST_Z_TRIM   = 8'h00;
  localparam logic [7:0] PCR_RST_POWER_SAVING_CONFIG = 8'h03;
  localparam logic [7:0] PCR_RST_SENS_EN  = 8'h00;
  localparam logic [7:0] PCR_READ_ZERO    = 8'h00;

  // Field positions and writable masks
  localparam int         PCR_BIT_APS      = 0;
  localparam int         PCR_BIT_FSW      = 1;
  localparam int         PCR_BIT_AUX_EN   = 0;
  localparam int         PCR_BIT_ACC_EN   = 2;
  localparam logic [7:0] PCR_MASK_PWR     = 8'h03;
  localparam logic [7:0] PCR_MASK_SENS    = 8'h05;

  // Command codes
  localparam logic [7:0] PCR_CMD_NVM_PROG = 8'hA0;
  localparam logic [7:0] PCR_CMD_Q_FLUSH  = 8'hB0;
  localparam logic [7:0] PCR_CMD_SOFT_RST = 8'hB6;

  // Serial frame layout
  localparam logic [2:0] PCR_LAST_BIT     = 3'h7;
  localparam logic [1:0] PCR_PH_DATA      = 2'h2;

  // Address and data of one serial register write
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } pcr_wr_t;
endpackage

// ### src/pcr_power_command_regs.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: Z-axis trim register at 0x73, read-write, resets to zero, non-volatile backed.
// RULE2: Power saving off keeps fast clock; on allows slow clock when idle.
// RULE3: Power saving refuses queue reads unless self-wakeup bit set and interrupt seen.
// RULE4: Power configuration at 0x7C resets to 0x03; bits above one reserved.
// RULE5: Sensor enable bit 0 switches the auxiliary sensor on or off.
// RULE6: Sensor enable at 0x7D, bit 2 enables accelerometer, resets to zero.
// RULE7: Command register at 0x7E accepts codes and always reads zero.
// RULE8: Code 0xA0 copies non-volatile backed registers into non-volatile memory.
// RULE9: Code 0xB0 empties the sample queue, leaving its configuration untouched.
// RULE10: Code 0xB6 returns every user setting to its default value.
// RULE11: Primary interface starts in I2C mode after power-up.
// RULE12: SPI defaults to four wires; software may select three-wire bidirectional data.
// RULE13: Device is only ever a slave on the primary interface.
// RULE14: Enabled auxiliary interface fetches external sensor data automatically as master.
// RULE15: Shared data pin bidirectional in I2C and 3-wire, input in 4-wire; this bank drives it only for 3-wire SPI reads, never in I2C.
// RULE16: Either event line may become an input for queue synchronisation.
// RULE17: Three-wire select 0 picks 4-wire SPI, 1 picks 3-wire SPI.
// RULE18: Chip-select rising edge switches interface to SPI until next reset.
// RULE19: Unknown command codes are ignored with no state change.
module pcr_power_command_regs (
  // Core clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Primary interface pins
  input  wire logic        i_serial_clock_pin,
  input  wire logic        i_chip_select_pin_n,
  input  wire logic        i_shared_data_pin,
  output logic             o_shared_data_pin,
  output logic             o_shared_data_pin_oe,
  input  wire logic        i_serial_out_addr_pin,
  output logic             o_serial_out_addr_pin,
  output logic             o_serial_out_addr_pin_oe,
  // Event lines
  input  wire logic        i_event_line_one,
  output logic             o_event_line_one,
  output logic             o_event_line_one_oe,
  input  wire logic        i_event_line_two,
  output logic             o_event_line_two,
  output logic             o_event_line_two_oe,
  // Configuration held outside this bank
  input  wire logic        i_three_wire_select,
  input  wire logic        i_event_one_sync_in,
  input  wire logic        i_event_two_sync_in,
  input  wire logic        i_event_one_level,
  input  wire logic        i_event_two_level,
  // Core status
  input  wire logic        i_measuring,
  input  wire logic        i_queue_irq_seen,
  // Core controls
  output logic             o_fast_clk_en,
  output logic             o_queue_read_allow,
  output logic             o_acc_en,
  output logic             o_aux_fetch_en,
  output logic             o_spi_mode,
  output logic             o_i2c_addr_sel,
  output logic             o_queue_sync,
  output logic [7:0]       o_z_trim,
  output logic             o_nvm_prog,
  output logic [7:0]       o_nvm_image,
  output logic             o_queue_flush,
  output logic             o_soft_reset
);
  import pcr_pkg::*;

  // Register read decode, used only by the core-domain read answer
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] t,
                                        input logic [7:0] p, input logic [7:0] s);
    case (a)
      PCR_ADDR_Z_TRIM:   rd_mux = t;
      PCR_ADDR_POWER_SAVING_CONFIG: rd_mux = p;
      PCR_ADDR_SENS_EN:  rd_mux = s;
      default:           rd_mux = PCR_READ_ZERO; // Command entry and holes read zero
    endcase
  endfunction

  // ---------------- Link (serial clock) domain ----------------
  logic       sck;
  logic       frame_rst;
  logic [2:0] bit_reg;
  logic [1:0] phase_reg;
  logic [7:0] rx_reg;
  logic       rw_reg;
  logic [6:0] addr_reg;
  logic [7:0] tx_reg;
  pcr_wr_t    wr_hold_reg;
  logic       wr_tgl_reg;
  logic [6:0] rd_addr_reg;
  logic       rd_req_tgl_reg;
  logic [1:0] ack_sync_reg;
  logic [1:0] l_cfg3_reg;
  logic [1:0] l_spi_reg;
  logic [7:0] rx_next;
  logic       spi_mode_reg;
  logic [7:0] rd_data_reg;
  logic       rd_ack_tgl_reg;

  assign sck       = i_serial_clock_pin;
  assign frame_rst = i_chip_select_pin_n;
  assign rx_next   = {rx_reg[6:0], i_shared_data_pin};

  // Frame counters clear while chip select is high, so a frame always starts clean
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_reg   <= 3'h0;
      phase_reg <= 2'h0;
      rx_reg    <= 8'h00;
    end else begin
      bit_reg <= bit_reg + 3'h1;
      rx_reg  <= rx_next;
      if (bit_reg == PCR_LAST_BIT && phase_reg != PCR_PH_DATA) begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // Level crossings into the link domain; stale only on the first two edges
  always_ff @(posedge sck or posedge i_reset) begin
    if (i_reset) begin
      l_cfg3_reg <= 2'b00;
      l_spi_reg  <= 2'b00;
      ack_sync_reg <= 2'b00;
    end else begin
      l_cfg3_reg   <= {l_cfg3_reg[0], i_three_wire_select};
      l_spi_reg    <= {l_spi_reg[0], spi_mode_reg};
      ack_sync_reg <= {ack_sync_reg[0], rd_ack_tgl_reg};
    end
  end

  // Header capture, write hand-off and read requests; slave only, no master path [RULE13]
  always_ff @(posedge sck or posedge i_reset) begin
    if (i_reset) begin
      rw_reg         <= 1'b0;
      addr_reg       <= 7'h00;
      wr_hold_reg    <= '0;
      wr_tgl_reg     <= 1'b0;
      rd_addr_reg    <= 7'h00;
      rd_req_tgl_reg <= 1'b0;
      tx_reg         <= 8'h00;
    end else if (!frame_rst && l_spi_reg[1] && bit_reg == PCR_LAST_BIT) begin
      if (phase_reg == 2'h0) begin
        rw_reg   <= rx_next[7];
        addr_reg <= rx_next[6:0];
        if (rx_next[7]) begin
          rd_addr_reg    <= rx_next[6:0];
          rd_req_tgl_reg <= ~rd_req_tgl_reg;
        end
      end else if (!rw_reg) begin
        wr_hold_reg    <= '{addr: addr_reg, data: rx_next};
        wr_tgl_reg     <= ~wr_tgl_reg;
        addr_reg       <= addr_reg + 7'h01; // Burst writes step the address
      end else begin
        // Dummy byte ends, or a data byte ends: load next byte and fetch following address
        tx_reg         <= (ack_sync_reg[1] == rd_req_tgl_reg) ? rd_data_reg : PCR_READ_ZERO;
        rd_addr_reg    <= rd_addr_reg + 7'h01;
        rd_req_tgl_reg <= ~rd_req_tgl_reg;
      end
    end
  end

  // Read data shifts out on the falling edge; pin choice follows wire count [RULE12]
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      o_shared_data_pin        <= 1'b0;
      o_shared_data_pin_oe     <= 1'b0;
      o_serial_out_addr_pin    <= 1'b0;
      o_serial_out_addr_pin_oe <= 1'b0;
    end else begin
      o_shared_data_pin        <= tx_reg[PCR_LAST_BIT - bit_reg];
      o_serial_out_addr_pin    <= tx_reg[PCR_LAST_BIT - bit_reg];
      o_shared_data_pin_oe     <= l_spi_reg[1] && rw_reg && phase_reg == PCR_PH_DATA
                                  && l_cfg3_reg[1];  // [RULE15] [RULE17]
      o_serial_out_addr_pin_oe <= l_spi_reg[1] && rw_reg && phase_reg == PCR_PH_DATA
                                  && !l_cfg3_reg[1]; // [RULE17]
    end
  end

  // ---------------- Core clock domain ----------------
  logic [1:0] cs_sync_reg;
  logic       cs_prev_reg;
  logic [2:0] wr_sync_reg;
  logic [2:0] rd_sync_reg;
  logic [7:0] trim_reg;
  logic [7:0] pwr_reg;
  logic [7:0] sens_reg;
  logic       wr_stb;
  pcr_wr_t    wr_word;
  logic [1:0] addr_sync_reg;
  logic [1:0] ev1_sync_reg;
  logic [1:0] ev2_sync_reg;
  logic       ev1_prev_reg;
  logic       ev2_prev_reg;

  // Hold word is stable for eight link edges after its toggle, ample for this sync
  assign wr_stb  = wr_sync_reg[2] ^ wr_sync_reg[1];
  assign wr_word = wr_hold_reg;

  // Chip-select rising edge latches SPI mode; I2C until then [RULE11] [RULE18]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cs_sync_reg  <= 2'b11;
      cs_prev_reg  <= 1'b1;
      spi_mode_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], i_chip_select_pin_n};
      cs_prev_reg <= cs_sync_reg[1];
      if (cs_sync_reg[1] && !cs_prev_reg) begin
        spi_mode_reg <= 1'b1;
      end
    end
  end

  // Toggle synchronisers for write and read requests
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_sync_reg <= 3'b000;
      rd_sync_reg <= 3'b000;
    end else begin
      wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
      rd_sync_reg <= {rd_sync_reg[1:0], rd_req_tgl_reg};
    end
  end

  // Read answers; the command entry always answers zero [RULE7]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_data_reg    <= PCR_READ_ZERO;
      rd_ack_tgl_reg <= 1'b0;
    end else if (rd_sync_reg[2] ^ rd_sync_reg[1]) begin
      rd_data_reg    <= rd_mux(rd_addr_reg, trim_reg, pwr_reg, sens_reg);
      rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
    end
  end

  // Configuration registers; soft reset restores every default [RULE10]
  always_ff @(posedge i_clk) begin
    if (i_reset || (wr_stb && wr_word.addr == PCR_ADDR_CMD_ENTRY
                    && wr_word.data == PCR_CMD_SOFT_RST)) begin
      trim_reg <= PCR_RST_Z_TRIM;   // [RULE1]
      pwr_reg  <= PCR_RST_POWER_SAVING_CONFIG; // [RULE4]
      sens_reg <= PCR_RST_SENS_EN;  // [RULE6]
    end else if (wr_stb) begin
      case (wr_word.addr)
        PCR_ADDR_Z_TRIM:   trim_reg <= wr_word.data;                  // [RULE1]
        PCR_ADDR_POWER_SAVING_CONFIG: pwr_reg  <= wr_word.data & PCR_MASK_PWR;   // [RULE4]
        PCR_ADDR_SENS_EN:  sens_reg <= wr_word.data & PCR_MASK_SENS;  // [RULE5] [RULE6]
        default: ;
      endcase
    end
  end

  // Command pulses; any other code is dropped without effect [RULE19]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_nvm_prog    <= 1'b0;
      o_nvm_image   <= PCR_RST_Z_TRIM;
      o_queue_flush <= 1'b0;
      o_soft_reset  <= 1'b0;
    end else begin
      o_nvm_prog    <= 1'b0;
      o_queue_flush <= 1'b0;
      o_soft_reset  <= 1'b0;
      if (wr_stb && wr_word.addr == PCR_ADDR_CMD_ENTRY) begin
        case (wr_word.data)
          PCR_CMD_NVM_PROG: begin
            o_nvm_prog  <= 1'b1;      // [RULE8]
            o_nvm_image <= trim_reg;  // [RULE8]
          end
          PCR_CMD_Q_FLUSH:  o_queue_flush <= 1'b1; // [RULE9]
          PCR_CMD_SOFT_RST: o_soft_reset  <= 1'b1; // [RULE10]
          default: ;
        endcase
      end
    end
  end

  // Power and sensor controls toward the core
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fast_clk_en      <= 1'b1;
      o_queue_read_allow <= 1'b0;
      o_acc_en           <= 1'b0;
      o_aux_fetch_en     <= 1'b0;
      o_z_trim           <= PCR_RST_Z_TRIM;
      o_spi_mode         <= 1'b0;
    end else begin
      o_fast_clk_en      <= !pwr_reg[PCR_BIT_APS] || i_measuring; // [RULE2]
      o_queue_read_allow <= !pwr_reg[PCR_BIT_APS]
                            || (pwr_reg[PCR_BIT_FSW] && i_queue_irq_seen); // [RULE3]
      o_acc_en           <= sens_reg[PCR_BIT_ACC_EN]; // [RULE6]
      o_aux_fetch_en     <= sens_reg[PCR_BIT_AUX_EN]; // [RULE5] [RULE14]
      o_z_trim           <= trim_reg;
      o_spi_mode         <= spi_mode_reg;
    end
  end

  // Address strap pin is read only in I2C mode [RULE15]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_sync_reg  <= 2'b00;
      o_i2c_addr_sel <= 1'b0;
    end else begin
      addr_sync_reg <= {addr_sync_reg[0], i_serial_out_addr_pin};
      if (!spi_mode_reg) begin
        o_i2c_addr_sel <= addr_sync_reg[1];
      end
    end
  end

  // Event lines drive events or turn into queue sync inputs [RULE16]
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ev1_sync_reg        <= 2'b00;
      ev2_sync_reg        <= 2'b00;
      ev1_prev_reg        <= 1'b0;
      ev2_prev_reg        <= 1'b0;
      o_queue_sync        <= 1'b0;
      o_event_line_one    <= 1'b0;
      o_event_line_one_oe <= 1'b0;
      o_event_line_two    <= 1'b0;
      o_event_line_two_oe <= 1'b0;
    end else begin
      ev1_sync_reg        <= {ev1_sync_reg[0], i_event_line_one};
      ev2_sync_reg        <= {ev2_sync_reg[0], i_event_line_two};
      ev1_prev_reg        <= ev1_sync_reg[1];
      ev2_prev_reg        <= ev2_sync_reg[1];
      o_queue_sync        <= (i_event_one_sync_in && ev1_sync_reg[1] && !ev1_prev_reg)
                             || (i_event_two_sync_in && ev2_sync_reg[1] && !ev2_prev_reg);
      o_event_line_one    <= i_event_one_level;
      o_event_line_one_oe <= !i_event_one_sync_in;
      o_event_line_two    <= i_event_two_level;
      o_event_line_two_oe <= !i_event_two_sync_in;
    end
  end
endmodule // pcr_power_command_regs

// ### verification/pcr_regs_sva.sv
`timescale 1ns/1ns
module pcr_regs_sva (
  // Clock, reset and watched inputs
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_chip_select_pin_n,
  input wire logic       i_three_wire_select,
  input wire logic       i_measuring,
  input wire logic       i_queue_irq_seen,
  input wire logic       i_event_one_sync_in,
  input wire logic       i_event_one_level,
  // Watched outputs
  input wire logic       o_shared_data_pin_oe,
  input wire logic       o_serial_out_addr_pin_oe,
  input wire logic       o_event_line_one,
  input wire logic       o_event_line_one_oe,
  input wire logic       o_fast_clk_en,
  input wire logic       o_queue_read_allow,
  input wire logic       o_spi_mode,
  input wire logic       o_nvm_prog,
  input wire logic       o_queue_flush,
  input wire logic       o_soft_reset,
  input wire logic       o_acc_en,
  input wire logic [7:0] o_z_trim,
  input wire logic [7:0] o_nvm_image
);
  // All checks live in the core clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_fast; i_measuring |=> o_fast_clk_en; endproperty
  a_fast: assert property (p_fast) else $error("fast clock off while measuring");
  property p_allow; !o_fast_clk_en && o_queue_read_allow |-> $past(i_queue_irq_seen); endproperty
  a_allow: assert property (p_allow) else $error("queue read without interrupt");
  property p_prog; o_nvm_prog |=> !o_nvm_prog && o_nvm_image == $past(o_z_trim); endproperty
  a_prog: assert property (p_prog) else $error("bad save pulse or image");
  property p_flush; o_queue_flush |=> !o_queue_flush; endproperty
  a_flush: assert property (p_flush) else $error("flush pulse too long");
  property p_srst; o_soft_reset |-> ##[1:4] (o_z_trim == 8'h00 && !o_acc_en); endproperty
  a_srst: assert property (p_srst) else $error("settings kept after soft reset");
  property p_boot; $fell(i_reset) |-> !o_spi_mode; endproperty
  a_boot: assert property (p_boot) else $error("not in default mode after reset");
  property p_keep; o_spi_mode |=> o_spi_mode; endproperty
  a_keep: assert property (p_keep) else $error("serial mode lost");
  property p_oe3; o_shared_data_pin_oe |-> i_three_wire_select; endproperty
  a_oe3: assert property (p_oe3) else $error("data pin driven in 4-wire");
  property p_oe4; o_serial_out_addr_pin_oe |-> !i_three_wire_select; endproperty
  a_oe4: assert property (p_oe4) else $error("out pin driven in 3-wire");
  property p_idle;
    i_chip_select_pin_n [*2] |-> !o_shared_data_pin_oe && !o_serial_out_addr_pin_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("pin driven while deselected");
  property p_sync; i_event_one_sync_in [*2] |-> !o_event_line_one_oe; endproperty
  a_sync: assert property (p_sync) else $error("sync input still driven");
  property p_lvl; !$past(i_reset) |-> o_event_line_one == $past(i_event_one_level); endproperty
  a_lvl: assert property (p_lvl) else $error("event line lags level");
endmodule // pcr_regs_sva

bind pcr_power_command_regs pcr_regs_sva u_sva (.*);

// ### verification/pcr_host_model.sv
`timescale 1ns/1ns
module pcr_host_model (
  // Serial pins driven by the host
  output logic            o_sck,
  output logic            o_cs_n,
  output logic            o_mosi,
  // Read data from the device, and the three-wire select
  input  wire logic       i_miso4,
  input  wire logic       i_miso3,
  input  wire logic       i_three
);
  // Mode 00 frame, 160 ns bit time; clock idles low between frames
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat);
    logic [23:0] sh;
    int          nb;
    sh = {rd, a, wd, 8'h00};
    nb = rd ? 24 : 16;
    rdat = 8'h00;
    o_cs_n = 1'b0; // Each frame ends on a select rise
    #80;
    for (int i = 0; i < nb; i++) begin
      o_mosi = (rd && i >= 8) ? ~o_mosi : sh[23-i]; // Released line toggles
      #80 o_sck = 1'b1;
      if (i >= 16) rdat = {rdat[6:0], i_three ? i_miso3 : i_miso4};
      #80 o_sck = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #800;
  endtask
  // Idle pin levels
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
endmodule // pcr_host_model

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pcr_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, i_measuring = 1'b0, i_queue_irq_seen = 1'b0;
  logic i_three_wire_select = 1'b0, i_event_one_sync_in = 1'b0, i_event_two_sync_in = 1'b0;
  logic i_event_one_level = 1'b0, i_event_two_level = 1'b0, ev1 = 1'b0, ev2 = 1'b1;
  logic i_serial_clock_pin, i_chip_select_pin_n, mosi, i_shared_data_pin, i_serial_out_addr_pin;
  logic i_event_line_one, i_event_line_two, o_shared_data_pin, o_shared_data_pin_oe;
  logic o_serial_out_addr_pin, o_serial_out_addr_pin_oe, o_event_line_one, o_event_line_one_oe;
  logic o_event_line_two, o_event_line_two_oe, o_fast_clk_en, o_queue_read_allow, o_acc_en;
  logic o_aux_fetch_en, o_spi_mode, o_i2c_addr_sel, o_queue_sync, o_nvm_prog, o_queue_flush;
  logic o_soft_reset;
  logic strap = 1'b1; // Address strap level whenever the pin is not driven
  logic [7:0] o_z_trim, o_nvm_image, v, t;
  logic [6:0] a;
  int error_cnt = 0, n_tests = 0, n_prog = 0, n_fl = 0, n_sr = 0, n_qs = 0, q0;
  logic [7:0] cmds [4] = '{PCR_CMD_NVM_PROG, PCR_CMD_Q_FLUSH, 8'h11, PCR_CMD_SOFT_RST};
  logic [6:0] adrs [3] = '{PCR_ADDR_Z_TRIM, PCR_ADDR_POWER_SAVING_CONFIG, PCR_ADDR_SENS_EN};
  // Wire levels of the shared pins from every driver's enable
  assign i_shared_data_pin = o_shared_data_pin_oe ? o_shared_data_pin : mosi;
  assign i_serial_out_addr_pin = o_serial_out_addr_pin_oe ? o_serial_out_addr_pin : strap;
  assign i_event_line_one = o_event_line_one_oe ? o_event_line_one : ev1;
  assign i_event_line_two = o_event_line_two_oe ? o_event_line_two : ev2;
  pcr_power_command_regs dut (.*);
  pcr_host_model host (.o_sck(i_serial_clock_pin), .o_cs_n(i_chip_select_pin_n), .o_mosi(mosi),
    .i_miso4(o_serial_out_addr_pin), .i_miso3(o_shared_data_pin), .i_three(i_three_wire_select));
  always #50 i_clk = ~i_clk;
  // Count one-cycle pulses from the core
  always @(posedge i_clk) begin
    n_prog <= n_prog + o_nvm_prog;
    n_fl <= n_fl + o_queue_flush;
    n_sr <= n_sr + o_soft_reset;
    n_qs <= n_qs + o_queue_sync;
  end
  // Readable value of a register after a write of d
  function automatic logic [7:0] exp_rd(input logic [6:0] ad, input logic [7:0] d);
    if (ad == PCR_ADDR_POWER_SAVING_CONFIG) return d & 8'h03;
    if (ad == PCR_ADDR_SENS_EN) return d & 8'h05;
    return (ad == PCR_ADDR_CMD_ENTRY) ? 8'h00 : d;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    logic [7:0] x;
    host.frame(1'b0, ad, d, x);
  endtask
  task automatic rr(input logic [6:0] ad, input logic [7:0] e);
    logic [7:0] x;
    host.frame(1'b1, ad, 8'h00, x);
    chk(x, e);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    cyc(40000);
    error_cnt++;
    complete_run();
  end
  // Main sequence
  initial begin
    void'($urandom(80504));
    cyc(10);
    i_reset <= 1'b0;
    cyc(2);
    chk(o_spi_mode, 8'h00);
    chk(o_fast_clk_en, 8'h00);
    wr(PCR_ADDR_Z_TRIM, 8'h5A);
    chk(o_z_trim, 8'h00);
    chk(o_spi_mode, 8'h01);
    chk(o_i2c_addr_sel, 8'h01);
    cyc(1);
    strap <= 1'b0;
    rr(PCR_ADDR_POWER_SAVING_CONFIG, 8'h03);
    rr(PCR_ADDR_SENS_EN, 8'h00);
    rr(PCR_ADDR_Z_TRIM, 8'h00);
    for (int i = 0; i < 8; i++) begin
      a = adrs[$urandom % 3];
      v = $urandom;
      wr(a, v);
      rr(a, exp_rd(a, v));
    end
    wr(PCR_ADDR_SENS_EN, 8'hFF);
    chk({o_acc_en, o_aux_fetch_en}, 8'h03);
    for (int i = 0; i < 16; i++) begin
      wr(PCR_ADDR_POWER_SAVING_CONFIG, 8'(i[1:0]));
      cyc(1);
      i_measuring <= i[2];
      i_queue_irq_seen <= i[3];
      cyc(3);
      t = {!i[0] | i[2], !i[0] | (i[1] & i[3])};
      chk({o_fast_clk_en, o_queue_read_allow}, t);
    end
    t = $urandom;
    wr(PCR_ADDR_Z_TRIM, t);
    wr(PCR_ADDR_POWER_SAVING_CONFIG, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(PCR_ADDR_CMD_ENTRY, cmds[k]);
      v = {5'h00, k > 2, k > 0, 1'b1};
      chk(8'(n_prog + 2 * n_fl + 4 * n_sr), v);
      chk(o_z_trim, (k > 2) ? 8'h00 : t);
      if (k == 0) chk(o_nvm_image, t);
    end
    chk({o_acc_en, o_aux_fetch_en, o_spi_mode}, 8'h01);
    rr(PCR_ADDR_POWER_SAVING_CONFIG, 8'h03);
    rr(PCR_ADDR_CMD_ENTRY, 8'h00);
    chk(o_i2c_addr_sel, 8'h01);
    cyc(1);
    i_three_wire_select <= 1'b1;
    cyc(2);
    v = $urandom;
    wr(PCR_ADDR_Z_TRIM, v);
    rr(PCR_ADDR_Z_TRIM, v);
    i_event_one_sync_in <= 1'b1;
    i_event_two_level <= 1'b1;
    cyc(3);
    chk({o_event_line_one_oe, o_event_line_two, o_event_line_two_oe}, 8'h03);
    q0 = n_qs;
    ev1 <= 1'b1;
    cyc(2);
    ev1 <= 1'b0;
    cyc(6);
    chk(8'(n_qs - q0), 8'h01);
    complete_run();
  end
endmodule // tb_top
